// ===== verilog/axi_mm_interconnect_adapter.sv
`timescale 1ns/10ps
module axi_mm_interconnect_adapter #(
  parameter int AW            = 32,
  parameter int DW            = 32,
  parameter int IDW           = 4,
  parameter int PDW           = 16,
  parameter int REORDER_DEPTH = 0,
  parameter bit PSLVERR_USED  = 1'b1,
  parameter bit STRICT_ORDER  = 1'b0
) (
  // Clock, reset, enable
  input  wire logic            mclk,
  input  wire logic            arst_n,
  input  wire logic            ce,
  // Master write address
  input  wire logic [IDW-1:0]  m_aw_id,
  input  wire logic [AW-1:0]   m_aw_addr,
  input  wire logic [3:0]      m_aw_len,
  input  wire logic [2:0]      m_aw_size,
  input  wire logic [1:0]      m_aw_burst,
  input  wire logic [1:0]      m_aw_lock,
  input  wire logic [2:0]      m_aw_prot,
  input  wire logic            m_aw_valid,
  output logic                 m_aw_ready,
  // Master write data
  input  wire logic [DW-1:0]   m_w_data,
  input  wire logic [DW/8-1:0] m_w_strb,
  input  wire logic            m_w_last,
  input  wire logic            m_w_valid,
  output logic                 m_w_ready,
  // Master write response
  output logic [IDW-1:0]       m_b_id,
  output ic_pkg::resp_t        m_b_resp,
  output logic                 m_b_valid,
  input  wire logic            m_b_ready,
  // Master read address
  input  wire logic [IDW-1:0]  m_ar_id,
  input  wire logic [AW-1:0]   m_ar_addr,
  input  wire logic [3:0]      m_ar_len,
  input  wire logic [2:0]      m_ar_size,
  input  wire logic [1:0]      m_ar_burst,
  input  wire logic [1:0]      m_ar_lock,
  input  wire logic [2:0]      m_ar_prot,
  input  wire logic            m_ar_valid,
  output logic                 m_ar_ready,
  // Master read data
  output logic [IDW-1:0]       m_r_id,
  output logic [DW-1:0]        m_r_data,
  output ic_pkg::resp_t        m_r_resp,
  output logic                 m_r_last,
  output logic                 m_r_valid,
  input  wire logic            m_r_ready,
  // AXI slave command
  output logic [IDW-1:0]       s_ax_id,
  output logic [AW-1:0]        s_ax_addr,
  output logic [3:0]           s_ax_len,
  output logic [2:0]           s_ax_size,
  output logic [1:0]           s_ax_burst,
  output logic [1:0]           s_ax_lock,
  output logic [2:0]           s_ax_prot,
  output logic                 s_aw_valid,
  input  wire logic            s_aw_ready,
  output logic                 s_ar_valid,
  input  wire logic            s_ar_ready,
  // AXI slave data and responses
  output logic [DW-1:0]        s_w_data,
  output logic [DW/8-1:0]      s_w_strb,
  output logic                 s_w_last,
  output logic                 s_w_valid,
  input  wire logic            s_w_ready,
  input  wire ic_pkg::resp_t   s_b_resp,
  input  wire logic            s_b_valid,
  output logic                 s_b_ready,
  input  wire logic [DW-1:0]   s_r_data,
  input  wire ic_pkg::resp_t   s_r_resp,
  input  wire logic            s_r_last,
  input  wire logic            s_r_valid,
  output logic                 s_r_ready,
  // Avalon slave
  output logic [AW-1:0]        av_address,
  output logic                 av_read,
  output logic                 av_write,
  output logic [DW-1:0]        av_writedata,
  output logic [DW/8-1:0]      av_byteenable,
  input  wire logic            av_waitrequest,
  input  wire logic [DW-1:0]   av_readdata,
  input  wire logic            av_readdatavalid,
  // APB slave
  output logic [AW-1:0]        paddr,
  output logic                 psel,
  output logic                 penable,
  output logic                 pwrite,
  output logic [PDW-1:0]       pwdata,
  output logic [2:0]           pprot,
  input  wire logic [PDW-1:0]  prdata,
  input  wire logic            pready,
  input  wire logic            pslverr
);
  import ic_pkg::*;
  localparam int NB   = DW / 8;
  localparam int NBW  = $clog2(NB);
  localparam int PNBW = $clog2(PDW / 8);
  localparam int PW   = $clog2(DW / PDW);

  st_t              state;
  st_t              next_state;
  tgt_t             tgt;
  logic [IDW-1:0]   cmd_id;
  logic [AW-1:0]    cmd_addr;
  logic [3:0]       cmd_len;
  logic [2:0]       cmd_size;
  logic [1:0]       cmd_burst;
  logic [1:0]       cmd_lock;
  logic [2:0]       cmd_prot;
  logic [3:0]       beat;
  logic             sent;
  logic             wend;
  logic             last_wr;
  logic             wbuf_full;
  logic [DW-1:0]    wbuf_data;
  logic [NB-1:0]    wbuf_strb;
  logic             wbuf_last;
  logic             rbuf_full;
  logic [DW-1:0]    rbuf_data;
  resp_t            rbuf_resp;
  logic             rbuf_last;
  resp_t            bresp;
  logic             perr;
  logic             apb_en;
  logic [PW-1:0]    sub;
  logic [PW-1:0]    part;
  logic [DW-1:0]    rword;
  logic [NB-1:0]    lanes;
  logic [NBW-1:0]   lo;
  logic [NBW-1:0]   hi;

  function automatic tgt_t decode(input logic [AW-1:0] a);
    unique case (a[SEL_MSB:SEL_LSB])
      SEL_AXI: decode = TGT_AXI;
      SEL_AV:  decode = TGT_AV;
      SEL_APB: decode = TGT_APB;
      default: decode = TGT_NONE;
    endcase
  endfunction

  function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [2:0] sz,
                                          input logic [3:0] len, input logic [1:0] bt);
    logic [AW-1:0] inc;
    logic [AW-1:0] nxt;
    logic [AW-1:0] wm;
    inc = AW'(1) << sz;
    nxt = (a & ~(inc - AW'(1))) + inc;
    wm = ((AW'(len) + AW'(1)) << sz) - AW'(1);
    if (bt == BURST_FIXED) step = a;
    else if (bt == BURST_WRAP) step = (a & ~wm) | (nxt & wm);
    else step = nxt;
  endfunction

  lane_window #(.NB(NB), .NBW(NBW)) u_lanes (
    .off  (cmd_addr[NBW-1:0]),
    .size (cmd_size),
    .mask (lanes),
    .lo   (lo),
    .hi   (hi)
  );

  wire is_idle   = state == S_IDLE;
  wire aw_pref   = STRICT_ORDER || !last_wr;
  assign m_aw_ready = ce && is_idle && (aw_pref || !m_ar_valid);
  assign m_ar_ready = ce && is_idle && !(m_aw_valid && aw_pref);
  wire aw_take   = m_aw_valid && m_aw_ready;
  wire ar_take   = m_ar_valid && m_ar_ready;
  wire last_beat = beat == cmd_len;
  wire pdone     = psel && penable && pready;
  assign part    = lo[NBW-1:PNBW] + sub;
  wire pbeat     = pdone && part == hi[NBW-1:PNBW];
  wire rd_pb     = state == S_PBR && !rbuf_full;
  wire w_hs      = m_w_valid && m_w_ready;

  wire wpop = (state == S_AXW && s_w_valid && s_w_ready) || (state == S_AVW && av_write && !av_waitrequest)
              || (state == S_PBW && pbeat) || (state == S_ERRW && wbuf_full && ce);
  wire rpush = (state == S_AXR && s_r_valid && s_r_ready) || (state == S_AVR && av_readdatavalid && ce)
               || (state == S_PBR && pbeat) || (state == S_ERRR && !rbuf_full && ce);
  wire beat_adv = (wpop && state != S_AXW) || (rpush && state != S_AXR);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (aw_take) begin
          unique case (decode(m_aw_addr))
            TGT_AXI: next_state = S_AXW;
            TGT_AV:  next_state = S_AVW;
            TGT_APB: next_state = S_PBW;
            default: next_state = S_ERRW;
          endcase
        end else if (ar_take) begin
          unique case (decode(m_ar_addr))
            TGT_AXI: next_state = S_AXR;
            TGT_AV:  next_state = S_AVR;
            TGT_APB: next_state = S_PBR;
            default: next_state = S_ERRR;
          endcase
        end
      end
      S_AXW:                if (s_b_valid && s_b_ready) next_state = S_BRESP;
      S_AVW, S_PBW, S_ERRW: if (wpop && wbuf_last) next_state = S_BRESP;
      S_AXR:                if (rpush && s_r_last) next_state = S_DRAIN;
      S_AVR, S_PBR, S_ERRR: if (rpush && last_beat) next_state = S_DRAIN;
      S_BRESP:              if (m_b_valid && m_b_ready) next_state = S_IDLE;
      S_DRAIN:              if (!rbuf_full || (m_r_valid && m_r_ready)) next_state = S_IDLE;
      default:              next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) state <= S_IDLE;
    else if (ce) state <= next_state;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tgt <= TGT_AXI;
      cmd_id <= '0;
      cmd_addr <= '0;
      cmd_len <= BEAT_RESET;
      cmd_size <= 3'h0;
      cmd_burst <= 2'h0;
      cmd_lock <= 2'h0;
      cmd_prot <= 3'h0;
    end else if (ce) begin
      if (aw_take) begin
        tgt <= decode(m_aw_addr);
        cmd_id <= m_aw_id;
        cmd_addr <= m_aw_addr;
        cmd_len <= m_aw_len;
        cmd_size <= m_aw_size;
        cmd_burst <= m_aw_burst;
        cmd_lock <= m_aw_lock;
        cmd_prot <= m_aw_prot;
      end else if (ar_take) begin
        tgt <= decode(m_ar_addr);
        cmd_id <= m_ar_id;
        cmd_addr <= m_ar_addr;
        cmd_len <= m_ar_len;
        cmd_size <= m_ar_size;
        cmd_burst <= m_ar_burst;
        cmd_lock <= m_ar_lock;
        cmd_prot <= m_ar_prot;
      end else if (beat_adv) begin
        cmd_addr <= step(cmd_addr, cmd_size, cmd_len, cmd_burst);
      end
    end
  end

  // Beat count, command issue and write-end flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      beat <= BEAT_RESET;
      sent <= 1'b0;
      wend <= 1'b0;
      last_wr <= 1'b0;
    end else if (ce) begin
      if (aw_take || ar_take) begin
        beat <= BEAT_RESET;
        sent <= 1'b0;
        wend <= 1'b0;
        last_wr <= aw_take;
      end else begin
        if (beat_adv) beat <= beat + 4'h1;
        if (w_hs && m_w_last) wend <= 1'b1;
        if ((s_aw_valid && s_aw_ready) || (s_ar_valid && s_ar_ready)) sent <= 1'b1;
        else if (av_read && !av_waitrequest) sent <= 1'b1;
        else if (state == S_AVR && av_readdatavalid) sent <= 1'b0;
      end
    end
  end

  // Single-beat write holding register
  assign m_w_ready = ce && !wbuf_full && !wend && (state == S_AXW || state == S_AVW
                     || state == S_PBW || state == S_ERRW);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wbuf_full <= 1'b0;
      wbuf_data <= '0;
      wbuf_strb <= '0;
      wbuf_last <= 1'b0;
    end else if (ce) begin
      if (wpop) wbuf_full <= 1'b0;
      if (w_hs) begin
        wbuf_full <= 1'b1;
        wbuf_data <= m_w_data;
        wbuf_strb <= m_w_strb;
        wbuf_last <= m_w_last;
      end
    end
  end

  // Single-beat read holding register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rbuf_full <= 1'b0;
      rbuf_data <= '0;
      rbuf_resp <= RESP_OKAY;
      rbuf_last <= 1'b0;
    end else if (ce) begin
      if (m_r_valid && m_r_ready) rbuf_full <= 1'b0;
      if (rpush) begin
        rbuf_full <= 1'b1;
        rbuf_last <= (state == S_AXR) ? s_r_last : last_beat;
        unique case (state)
          S_AXR: begin
            rbuf_data <= s_r_data;
            rbuf_resp <= s_r_resp;
          end
          S_AVR: begin
            rbuf_data <= av_readdata;
            rbuf_resp <= RESP_OKAY;
          end
          S_PBR: begin
            rbuf_data <= rword;
            rbuf_data[part*PDW +: PDW] <= prdata;
            rbuf_resp <= (PSLVERR_USED && (perr || pslverr)) ? RESP_SLVERR : RESP_OKAY;
          end
          default: begin
            rbuf_data <= '0;
            rbuf_resp <= RESP_DECERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) bresp <= RESP_OKAY;
    else if (ce) begin
      if (aw_take) bresp <= (decode(m_aw_addr) == TGT_NONE) ? RESP_DECERR : RESP_OKAY;
      else if (s_b_valid && s_b_ready) bresp <= s_b_resp;
      else if (state == S_PBW && pdone && pslverr && PSLVERR_USED) bresp <= RESP_SLVERR;
    end
  end

  // APB phase, sub-transfer index and read assembly
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      apb_en <= 1'b0;
      sub <= '0;
      perr <= 1'b0;
      rword <= '0;
    end else if (ce) begin
      if (pdone) apb_en <= 1'b0;
      else if (psel) apb_en <= 1'b1;
      if (pbeat) sub <= '0;
      else if (pdone) sub <= sub + PW'(1);
      if (pbeat) perr <= 1'b0;
      else if (pdone && pslverr) perr <= 1'b1;
      if (pdone && !pwrite) rword[part*PDW +: PDW] <= prdata;
    end
  end

  assign s_ax_id    = (REORDER_DEPTH > 0) ? '0 : cmd_id;
  assign s_ax_addr  = cmd_addr;
  assign s_ax_len   = cmd_len;
  assign s_ax_size  = cmd_size;
  assign s_ax_burst = cmd_burst;
  assign s_ax_lock  = {1'b0, cmd_lock[0]};
  assign s_ax_prot  = cmd_prot;
  assign s_aw_valid = ce && state == S_AXW && !sent;
  assign s_ar_valid = ce && state == S_AXR && !sent;
  assign s_w_data   = wbuf_data;
  assign s_w_strb   = wbuf_strb;
  assign s_w_last   = wbuf_last;
  assign s_w_valid  = ce && state == S_AXW && wbuf_full;
  assign s_b_ready  = ce && state == S_AXW && wend && !wbuf_full && sent;
  assign s_r_ready  = ce && state == S_AXR && sent && !rbuf_full;

  assign av_address   = {cmd_addr[AW-1:NBW], {NBW{1'b0}}};
  assign av_write     = ce && state == S_AVW && wbuf_full;
  assign av_read      = ce && state == S_AVR && !sent && !rbuf_full;
  assign av_writedata = wbuf_data;
  assign av_byteenable = (state == S_AVW) ? (lanes & wbuf_strb) : lanes;

  assign paddr   = {cmd_addr[AW-1:NBW], part, {PNBW{1'b0}}};
  assign psel    = ce && ((state == S_PBW && wbuf_full) || rd_pb || apb_en);
  assign penable = apb_en;
  assign pwrite  = state == S_PBW;
  assign pwdata  = wbuf_data[part*PDW +: PDW];
  assign pprot   = cmd_prot;

  assign m_b_id    = cmd_id;
  assign m_b_resp  = bresp;
  assign m_b_valid = ce && state == S_BRESP;
  assign m_r_id    = cmd_id;
  assign m_r_data  = rbuf_data;
  assign m_r_resp  = rbuf_resp;
  assign m_r_last  = rbuf_last;
  assign m_r_valid = ce && rbuf_full;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence

  a_prot_passed: assert property (aw_take |=> s_ax_prot == $past(m_aw_prot))
    else $error("protection bits altered");
  a_no_locked_out: assert property ((s_aw_valid || s_ar_valid) |-> !s_ax_lock[1])
    else $error("locked access issued");
  a_av_okay_resp: assert property (m_b_valid && tgt == TGT_AV |-> m_b_resp == RESP_OKAY)
    else $error("Avalon write answered non-OKAY");
  a_id_constant: assert property (s_aw_valid && REORDER_DEPTH > 0 |-> s_ax_id == '0)
    else $error("reordering slave saw master ID");
  a_id_passed: assert property (ar_take && REORDER_DEPTH == 0 |=> s_ax_id == $past(m_ar_id))
    else $error("ID not passed through");
  a_one_slave: assert property ((s_aw_valid || s_ar_valid) |-> !(av_read || av_write || psel))
    else $error("two slaves active at once");
  a_no_new_cmd: assert property (ar_take |=> !m_aw_ready [*2])
    else $error("command taken while read pending");
  a_av_aligned: assert property ((av_read || av_write) |-> av_address[NBW-1:0] == '0)
    else $error("Avalon address unaligned");
  a_be_by_size: assert property (av_write |-> $countones(av_byteenable) <= (1 << cmd_size))
    else $error("byte enables exceed size");
  a_apb_phases: assert property (apb_setup |=> apb_access)
    else $error("APB access phase missing");
  a_apb_aligned: assert property (psel |-> paddr[PNBW-1:0] == '0)
    else $error("APB address unaligned");
  a_apb_slverr: assert property (state == S_PBW && pdone && pslverr && PSLVERR_USED
                                 |=> bresp == RESP_SLVERR)
    else $error("APB error not mapped");
endmodule

// ===== verilog/ic_pkg.sv
// How it works
// - Protection bits pass from master to slave untouched.
// - Non-reordering AXI slaves see lock, ID and response unchanged for exclusives.
// - Avalon accesses answer OKAY only; the locked lock code never leaves.
// - AXI slave response codes, non-OKAY included, return to the master.
// - Responses return in command order.
// - Reordering AXI slave gets a constant zero ID.
// - Non-reordering AXI slave gets the master's ID.
// - Only one slave has outstanding work; other targets stall until responses return.
// - Strict-order option keeps reads behind pending writes.
// - Narrow transfers accepted; AXI write strobes carried through.
// - Byte lane zero is data bits 7 to 0.
// - Avalon commands are aligned to the Avalon word.
// - AXI slave receives address, length, size, burst and protection unchanged.
// - Downsized transfers toward the narrow slave are aligned.
// - Write byte enables follow transaction size.
// - Narrow read bursts become single reads with only needed byte enables.
// - Byte enables come from size; read start rounds down to word.
// - Only one APB select line is produced.
// - Bursts to APB become single non-burst transfers.
// - Wide beats are split into APB-width transfers.
// - APB error maps to SLVERR; without error signal answer OKAY.
package ic_pkg;
  typedef logic [1:0] resp_t;
  localparam resp_t      RESP_OKAY   = 2'h0;
  localparam resp_t      RESP_SLVERR = 2'h2;
  localparam resp_t      RESP_DECERR = 2'h3;
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_WRAP  = 2'h2;
  localparam int         SEL_MSB     = 31;
  localparam int         SEL_LSB     = 28;
  localparam logic [3:0] SEL_AXI     = 4'h0;
  localparam logic [3:0] SEL_AV      = 4'h1;
  localparam logic [3:0] SEL_APB     = 4'h2;
  localparam logic [3:0] BEAT_RESET  = 4'h0;
  typedef enum logic [1:0] {
    TGT_AXI  = 2'h0,
    TGT_AV   = 2'h1,
    TGT_APB  = 2'h2,
    TGT_NONE = 2'h3
  } tgt_t;
  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_AXW   = 11'h002,
    S_AVW   = 11'h004,
    S_PBW   = 11'h008,
    S_ERRW  = 11'h010,
    S_AXR   = 11'h020,
    S_AVR   = 11'h040,
    S_PBR   = 11'h080,
    S_ERRR  = 11'h100,
    S_BRESP = 11'h200,
    S_DRAIN = 11'h400
  } st_t;
endpackage

// ===== verilog/lane_window.sv
`timescale 1ns/10ps
module lane_window #(
  parameter int NB  = 4,
  parameter int NBW = 2
) (
  // Beat position and size
  input  wire logic [NBW-1:0] off,
  input  wire logic [2:0]     size,
  // Size-aligned lane window
  output logic      [NB-1:0]  mask,
  output logic      [NBW-1:0] lo,
  output logic      [NBW-1:0] hi
);
  always_comb begin
    int nb;
    int base;
    nb = 1;
    base = 0;
    nb = (int'(size) >= NBW) ? NB : (1 << size);
    base = int'(off) & ~(nb - 1);
    lo = NBW'(base);
    hi = NBW'(base + nb - 1);
    for (int i = 0; i < NB; i++) begin
      mask[i] = (i >= base) && (i < base + nb);
    end
  end
endmodule

// ===== sim/far_side.sv
`timescale 1ns/10ps
module far_side (
  // Clock, reset and answer mode
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          slow,
  input  wire logic          err,
  // AXI slave
  input  wire logic [3:0]    s_ax_len,
  input  wire logic          s_aw_valid,
  input  wire logic          s_ar_valid,
  input  wire logic          s_w_valid,
  input  wire logic          s_w_last,
  input  wire logic          s_b_ready,
  input  wire logic          s_r_ready,
  output logic               s_aw_ready,
  output logic               s_ar_ready,
  output logic               s_w_ready,
  output ic_pkg::resp_t      s_b_resp,
  output logic               s_b_valid,
  output logic [31:0]        s_r_data,
  output ic_pkg::resp_t      s_r_resp,
  output logic               s_r_last,
  output logic               s_r_valid,
  // Avalon slave
  input  wire logic          av_read,
  output logic               av_waitrequest,
  output logic [31:0]        av_readdata,
  output logic               av_readdatavalid,
  // APB slave
  input  wire logic [31:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  output logic [15:0]        prdata,
  output logic               pready,
  output logic               pslverr
);
  import ic_pkg::*;
  logic       tick;
  logic       go;
  logic [4:0] rcnt;
  // Slow mode answers only every other cycle, except AXI read data beats, which follow on consecutive cycles
  assign go = !slow || tick;
  assign s_aw_ready = s_aw_valid && go;
  assign s_ar_ready = s_ar_valid && go;
  assign s_w_ready = go;
  assign av_waitrequest = !go;
  assign pready = go;
  assign pslverr = err && penable && go;
  assign s_b_resp = err ? RESP_SLVERR : RESP_OKAY;
  assign s_r_resp = s_b_resp;
  assign s_r_valid = rcnt != 5'h0;
  assign s_r_last = rcnt == 5'h1;
  // Released data lines toggle so stale values never look valid
  assign s_r_data = s_r_valid ? 32'hc0de0000 | 32'(rcnt) : {32{tick}};
  assign av_readdata = av_readdatavalid ? 32'ha5a51234 : {32{tick}};
  assign prdata = psel ? paddr[15:0] : {16{tick}};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
      rcnt <= 5'h0;
      s_b_valid <= 1'b0;
      av_readdatavalid <= 1'b0;
    end else begin
      tick <= ~tick;
      av_readdatavalid <= av_read && go;
      if (s_w_valid && go && s_w_last)
        s_b_valid <= 1'b1;
      else if (s_b_ready)
        s_b_valid <= 1'b0;
      if (s_ar_valid && go)
        rcnt <= 5'(s_ax_len) + 5'h1;
      else if (s_r_valid && s_r_ready)
        rcnt <= rcnt - 5'h1;
    end
  end
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import ic_pkg::*;
  logic        mclk, arst_n, ce, slow, err, m_aw_valid, m_aw_ready, m_w_last, m_w_valid, m_w_ready, m_b_valid;
  logic        m_b_ready, m_ar_valid, m_ar_ready, m_r_last, m_r_valid, m_r_ready, s_aw_valid, s_aw_ready, s_ar_valid;
  logic        s_ar_ready, s_w_last, s_w_valid, s_w_ready, s_b_valid, s_b_ready, s_r_last, s_r_valid, s_r_ready;
  logic        av_read, av_write, av_waitrequest, av_readdatavalid, psel, penable, pwrite, pready, pslverr;
  logic [3:0]  m_aw_id, m_aw_len, m_ar_id, m_ar_len, m_b_id, m_r_id, s_ax_id, s_ax_len, m_w_strb, s_w_strb;
  logic [3:0]  av_byteenable, id, be, len;
  logic [31:0] m_aw_addr, m_ar_addr, m_w_data, m_r_data, s_ax_addr, s_w_data, s_r_data, adr;
  logic [31:0] av_address, av_writedata, av_readdata, paddr;
  logic [2:0]  m_aw_size, m_aw_prot, m_ar_size, m_ar_prot, s_ax_size, s_ax_prot, pprot, prot, sz;
  logic [1:0]  m_aw_burst, m_aw_lock, m_ar_burst, m_ar_lock, s_ax_burst, s_ax_lock, lock;
  logic [15:0] pwdata, prdata;
  resp_t       m_b_resp, m_r_resp, s_b_resp, s_r_resp;
  logic [38:0] note_q[$];
  logic [36:0] w_q[$];
  logic [36:0] wb;
  int          fails, n_checks, seed, i;

  axi_mm_interconnect_adapter u_dut (.*);
  far_side u_far (.*);

  always #4 mclk = ~mclk;

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic hold(ref logic rdy);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rdy !== 1'b1 && n < 300);
    if (rdy !== 1'b1) begin
      fails++;
      complete_run();
    end else
      #1;
  endtask

  // Waits whole cycles so the next request still starts just after an edge
  task automatic drain();
    int n;
    n = 0;
    while (note_q.size() != 0 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (note_q.size() != 0) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic note(input resp_t r, input logic [31:0] d, input bit l = 1'b1);
    note_q.push_back({l, id, r, d});
  endtask

  task automatic xfer(input bit wr, input bit e, input logic [31:0] a, input logic [2:0] s, input logic [3:0] ln,
                      input logic [3:0] st, input logic [3:0] b);
    drain();
    {err, slow, be, adr, sz, len} = {e, 1'($random(seed)), b, a, s, ln};
    {id, prot, lock} = 9'($random(seed));
    if (wr) begin
      {m_aw_id, m_aw_addr, m_aw_len, m_aw_size, m_aw_burst} = {id, a, ln, s, 2'h1};
      {m_aw_lock, m_aw_prot, m_aw_valid} = {lock, prot, 1'b1};
      // Frozen block must not take the pending command
      if (slow) begin
        ce = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        ce = 1'b1;
      end
      hold(m_aw_ready);
      m_aw_valid = 1'b0;
      for (int k = 0; k <= ln; k++) begin
        {m_w_data, m_w_strb, m_w_last, m_w_valid} = {$random(seed), st, k == ln, 1'b1};
        if (a[31:28] <= SEL_APB)
          w_q.push_back({m_w_data, st, m_w_last});
        hold(m_w_ready);
      end
      m_w_valid = 1'b0;
    end else begin
      {m_ar_id, m_ar_addr, m_ar_len, m_ar_size, m_ar_burst} = {id, a, ln, s, 2'h1};
      {m_ar_lock, m_ar_prot, m_ar_valid} = {lock, prot, 1'b1};
      hold(m_ar_ready);
      m_ar_valid = 1'b0;
    end
  endtask

  always @(posedge mclk) begin
    if (m_b_valid === 1'b1 && m_b_ready)
      check("write answer", note_q.size() ? 48'(note_q.pop_front()) : 48'hx, {1'b1, m_b_id, m_b_resp, 32'h0});
    if (m_r_valid === 1'b1 && m_r_ready)
      check("read answer", note_q.size() ? 48'(note_q.pop_front()) : 48'hx,
            {m_r_last, m_r_id, m_r_resp, m_r_data});
    if (s_aw_valid === 1'b1 && s_aw_ready || s_ar_valid === 1'b1 && s_ar_ready) begin
      check("slave command", {id, adr, sz, lock & 2'h1, prot},
            {s_ax_id, s_ax_addr, s_ax_size, s_ax_lock, s_ax_prot});
      check("slave burst shape", {len, 2'h1}, {s_ax_len, s_ax_burst});
    end
    if (s_w_valid === 1'b1 && s_w_ready)
      check("slave write beat", w_q.size() ? 48'(w_q.pop_front()) : 48'hx, {s_w_data, s_w_strb, s_w_last});
    if ((av_read === 1'b1 || av_write === 1'b1) && !av_waitrequest)
      check("avalon command", {adr[31:2], 2'h0, be}, {av_address, av_byteenable});
    if (av_write === 1'b1 && !av_waitrequest) begin
      wb = w_q.size() ? w_q.pop_front() : 37'hx;
      check("avalon write data", wb[36:5], av_writedata);
    end
    if (psel === 1'b1 && penable === 1'b1 && pready && pwrite === 1'b1) begin
      wb = w_q.size() ? w_q[0] : 37'hx;
      check("apb write data", paddr[1] ? wb[36:21] : wb[20:5], pwdata);
      if (paddr[1] && w_q.size())
        void'(w_q.pop_front());
    end
    if (ce === 1'b0)
      check("frozen ready", 2'h0, {m_aw_ready, m_ar_ready});
    if (psel === 1'b1 && penable === 1'b1 && pready)
      check("apb protection", prot, pprot);
  end

  initial begin
    seed = 32'h81cf;
    {mclk, arst_n, ce, m_b_ready, m_r_ready, fails, n_checks} = {5'h7, 64'h0};
    {m_aw_id, m_aw_addr, m_aw_len, m_aw_size, m_aw_burst, m_aw_lock, m_aw_prot, m_aw_valid} = '0;
    {m_ar_id, m_ar_addr, m_ar_len, m_ar_size, m_ar_burst, m_ar_lock, m_ar_prot, m_ar_valid} = '0;
    {m_w_data, m_w_strb, m_w_last, m_w_valid, slow, err} = '0;
    repeat (4) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    // short bursts stay in one page
    for (i = 0; i < 6; i++) begin
      xfer(1, i[1], 32'h100, 3'h2, 4'(i % 2), 4'($random(seed)), 4'h0);
      note(i[1] ? RESP_SLVERR : RESP_OKAY, 32'h0);
      xfer(0, i[1], 32'h200, 3'h2, 4'(i % 3), 4'hf, 4'h0);
      for (int k = 0; k <= i % 3; k++)
        note(i[1] ? RESP_SLVERR : RESP_OKAY, 32'hc0de0000 | 32'(i % 3 + 1 - k), k == i % 3);
    end
    xfer(1, 1, 32'h1000_0006, 3'h0, 4'h0, 4'h4, 4'h4);
    note(RESP_OKAY, 32'h0);
    xfer(0, 1, 32'h1000_0001, 3'h2, 4'h0, 4'hf, 4'hf);
    note(RESP_OKAY, 32'ha5a51234);
    xfer(0, 1, 32'h2000_0010, 3'h2, 4'h0, 4'hf, 4'h0);
    note(RESP_SLVERR, 32'h00120010);
    // full-width writes only to the narrow slave
    for (i = 0; i < 2; i++) begin
      xfer(1, i[0], 32'h2000_0020, 3'h2, 4'h1, 4'hf, 4'h0);
      note(i[0] ? RESP_SLVERR : RESP_OKAY, 32'h0);
    end
    xfer(1, 0, 32'h3000_0000, 3'h2, 4'h0, 4'hf, 4'h0);
    note(RESP_DECERR, 32'h0);
    drain();
    if (w_q.size() != 0) begin
      fails++;
      $display("unexpected slave write beats left: expected 0, seen %0d", w_q.size());
    end
    complete_run();
  end
endmodule
